// ### hw/timer_pin_io_params.svh
// offsets, field positions and reset values of the channel 3..5 pin select block
// assumes: included by bare name from every file that needs a constant
`ifndef TIMER_PIN_IO_PARAMS_SVH
`define TIMER_PIN_IO_PARAMS_SVH

// wishbone byte offsets of the registers
`define OFS_CH3_UPPER_SEL   8'h00
`define OFS_CH3_LOWER_SEL   8'h04
`define OFS_CH4_SEL         8'h08
`define OFS_CH5_SEL         8'h0c
`define OFS_CH3_MODE        8'h10
`define OFS_CH3_FIRST_GR    8'h14
`define OFS_CH3_THIRD_GR    8'h18
`define OFS_CH4_FIRST_GR    8'h1c
`define OFS_CH5_FIRST_GR    8'h20
`define OFS_PIN_STATUS      8'h24

// field layout of a pin action nibble
`define FLD_TOP_BIT         3
`define FLD_LEVEL_BIT       2
`define FLD_EDGE_BIT        1
`define FLD_LOW_BIT         0

// buffer pair enable inside the channel 3 mode register
`define MODE_BUF_A_BIT      4

// reset values
`define RST_SEL             8'h00
`define RST_MODE            8'h00
`define RST_GR              16'hffff

`endif

// ### hw/timer_pin_io_pkg.sv
// types shared by the channel 3..5 pin select block
// assumes: nothing beyond the params header
package timer_pin_io_pkg;

  // decoded meaning of one pin action nibble
  typedef enum logic [2:0] {
    MODE_OFF,
    MODE_CLR,
    MODE_SET,
    MODE_TGL,
    MODE_CAP_RISE,
    MODE_CAP_FALL,
    MODE_CAP_BOTH,
    MODE_CAP_CASCADE
  } pin_mode_t;

  // one two-way timer pin as seen at a design port
  typedef struct packed {
    logic out;
    logic oe_n;
  } pin_drive_t;

  // counter view of one channel
  typedef struct packed {
    logic [15:0] value;
    logic        tick;
  } count_view_t;

endpackage

// ### hw/pin_edge_detect.sv
// rising and falling edge detector for one synchronous timer pin
// assumes: pin_i already synchronous to clk_i
`timescale 1ns/100ps
module pin_edge_detect (
  input  wire logic clk_i,   // clock
  input  wire logic rst_i,   // synchronous reset, active high
  input  wire logic pin_i,   // pin level
  output logic      rise_o,  // rising edge this cycle
  output logic      fall_o   // falling edge this cycle
);
  logic last;
  logic next_last;

  always_comb begin
    next_last = pin_i;
    rise_o    = pin_i & ~last;
    fall_o    = ~pin_i & last;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last <= 1'b0;
    end else begin
      last <= next_last;
    end
  end
endmodule // pin_edge_detect

// ### hw/pin_action_unit.sv
// one general register with its pin: output compare or input capture by a 4-bit action field
// assumes: counter value and tick come from the channel counter; pin input is synchronous
`timescale 1ns/100ps
`include "timer_pin_io_params.svh"
module pin_action_unit
  import timer_pin_io_pkg::*;
#(
  parameter int          W           = 16,   // general register width
  parameter bit          HAS_CASCADE = 1'b1, // 11xx selects a cascade source
  parameter bit          FLAT_CAP    = 1'b0  // level bit ignored in capture codes
) (
  input  wire logic         clk_i,      // clock
  input  wire logic         rst_i,      // synchronous reset, active high
  input  wire logic [3:0]   field_i,    // pin action field
  input  wire logic         inhibit_i,  // field invalid, no events
  input  wire logic [W-1:0] count_i,    // channel counter value
  input  wire logic         tick_i,     // counter advanced this cycle
  input  wire logic         cascade_i,  // cascade capture source event
  input  wire logic         pin_i,      // pin input level
  input  wire logic         wr_i,       // software write of general register
  input  wire logic [W-1:0] wr_data_i,  // write data
  output logic [W-1:0]      gr_o,       // general register
  output pin_drive_t        pin_o,      // pin drive, oe_n low when driving
  output logic              event_o     // registered compare match or capture pulse
);
  pin_mode_t    mode;
  logic         rise;
  logic         fall;
  logic         match;
  logic         capture;
  logic         out_mode;
  logic [3:0]   last_field;
  logic [3:0]   next_last_field;
  logic [W-1:0] next_gr;
  pin_drive_t   next_pin;
  logic         next_event;

  pin_edge_detect u_edge (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  (pin_i),
    .rise_o (rise),
    .fall_o (fall)
  );

  always_comb begin
    if (!field_i[`FLD_TOP_BIT]) begin
      case (field_i[1:0])
        2'b01:   mode = MODE_CLR;
        2'b10:   mode = MODE_SET;
        2'b11:   mode = MODE_TGL;
        default: mode = MODE_OFF;
      endcase
    end else if (field_i[`FLD_LEVEL_BIT] && HAS_CASCADE && !FLAT_CAP) begin
      mode = MODE_CAP_CASCADE;
    end else if (field_i[`FLD_EDGE_BIT]) begin
      mode = MODE_CAP_BOTH;
    end else if (field_i[`FLD_LOW_BIT]) begin
      mode = MODE_CAP_FALL;
    end else begin
      mode = MODE_CAP_RISE;
    end
  end

  always_comb begin
    out_mode = !field_i[`FLD_TOP_BIT];
    match    = out_mode && !inhibit_i && tick_i && (count_i == gr_o);
    capture  = 1'b0;
    case (mode)
      MODE_CAP_RISE:    capture = rise;
      MODE_CAP_FALL:    capture = fall;
      MODE_CAP_BOTH:    capture = rise | fall;
      MODE_CAP_CASCADE: capture = cascade_i;
      default:          capture = 1'b0;
    endcase
    capture         = capture & !inhibit_i;
    next_last_field = field_i;
    next_event      = match | capture;
    next_gr         = gr_o;
    if (capture) begin
      next_gr = count_i;
    end else if (wr_i) begin
      next_gr = wr_data_i;
    end
    next_pin.oe_n = !(out_mode && mode != MODE_OFF && !inhibit_i);
    next_pin.out  = pin_o.out;
    if (out_mode && field_i != last_field) begin
      next_pin.out = field_i[`FLD_LEVEL_BIT];
    end else if (match) begin
      case (mode)
        MODE_CLR: next_pin.out = 1'b0;
        MODE_SET: next_pin.out = 1'b1;
        MODE_TGL: next_pin.out = ~pin_o.out;
        default:  next_pin.out = pin_o.out;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gr_o       <= W'(`RST_GR);
      pin_o      <= '{out: 1'b0, oe_n: 1'b1};
      event_o    <= 1'b0;
      last_field <= 4'h0;
    end else begin
      gr_o       <= next_gr;
      pin_o      <= next_pin;
      event_o    <= next_event;
      last_field <= next_last_field;
    end
  end
endmodule // pin_action_unit

// ### hw/timer_pin_io_select_ch3_5.sv
// pin action select for timer channels 3, 4 and 5 with a classic wishbone register slave
// assumes: counters live outside and present value plus a one-cycle tick; pins are synchronous
//
// Local design decisions: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
`include "timer_pin_io_params.svh"
module timer_pin_io_select_ch3_5
  import timer_pin_io_pkg::*;
#(
  parameter int W = 16  // counter and general register width
) (
  input  wire logic         clk_i,        // clock, 100 MHz
  input  wire logic         rst_i,        // synchronous reset, active high
  input  wire logic         cyc_i,        // wishbone cycle
  input  wire logic         stb_i,        // wishbone strobe
  input  wire logic         we_i,         // wishbone write enable
  input  wire logic [7:0]   adr_i,        // wishbone byte address
  input  wire logic [3:0]   sel_i,        // wishbone byte selects
  input  wire logic [31:0]  dat_i,        // wishbone write data
  output logic [31:0]       dat_o,        // wishbone read data
  output logic              ack_o,        // wishbone acknowledge
  input  wire logic [W-1:0] ch3_count_i,  // channel 3 counter value
  input  wire logic         ch3_tick_i,   // channel 3 counter advanced
  input  wire logic [W-1:0] ch4_count_i,  // channel 4 counter value
  input  wire logic         ch4_tick_i,   // channel 4 counter counted up or down
  input  wire logic [W-1:0] ch5_count_i,  // channel 5 counter value
  input  wire logic         ch5_tick_i,   // channel 5 counter advanced
  input  wire logic         ch3_pin_a_i,  // channel 3 pin a input
  output logic              ch3_pin_a_o,  // channel 3 pin a output
  output logic              ch3_pin_a_oe_n_o, // channel 3 pin a enable, low drives
  input  wire logic         ch3_pin_c_i,  // channel 3 pin c input
  output logic              ch3_pin_c_o,  // channel 3 pin c output
  output logic              ch3_pin_c_oe_n_o, // channel 3 pin c enable, low drives
  input  wire logic         ch4_pin_a_i,  // channel 4 pin a input
  output logic              ch4_pin_a_o,  // channel 4 pin a output
  output logic              ch4_pin_a_oe_n_o, // channel 4 pin a enable, low drives
  input  wire logic         ch5_pin_a_i,  // channel 5 pin a input
  output logic              ch5_pin_a_o,  // channel 5 pin a output
  output logic              ch5_pin_a_oe_n_o, // channel 5 pin a enable, low drives
  output logic [3:0]        event_o       // events: ch3 first, ch3 third, ch4, ch5
);
  localparam int NU = 4;

  // software registers
  logic [7:0]  ch3_upper_pin_io_select;
  logic [7:0]  ch3_lower_pin_io_select;
  logic [7:0]  ch4_pin_io_select;
  logic [7:0]  ch5_pin_io_select;
  logic [7:0]  ch3_mode_reg;
  logic [7:0]  next_ch3_upper_pin_io_select;
  logic [7:0]  next_ch3_lower_pin_io_select;
  logic [7:0]  next_ch4_pin_io_select;
  logic [7:0]  next_ch5_pin_io_select;
  logic [7:0]  next_ch3_mode_reg;

  // bus slave state
  logic        next_ack;
  logic [31:0] next_dat;
  logic        wr_go;
  logic        buffer_pair_a_enable;
  logic [1:0]  lanes;
  logic [W-1:0] wr_word;

  // per unit wiring, index 0 ch3 first, 1 ch3 third, 2 ch4 first, 3 ch5 first
  logic [3:0]   first_pin_action_field;
  logic [3:0]   third_pin_action_field;
  logic [3:0]   u_field   [NU];
  logic         u_inhibit [NU];
  logic [W-1:0] u_count   [NU];
  logic         u_tick    [NU];
  logic         u_cascade [NU];
  logic         u_pin_in  [NU];
  logic         u_wr      [NU];
  logic [W-1:0] u_gr      [NU];
  pin_drive_t   u_pin     [NU];
  logic         u_event   [NU];
  logic [7:0]   u_ofs     [NU];

  logic [W-1:0] ch3_first_general_reg;
  logic [W-1:0] ch3_third_general_reg;
  logic [W-1:0] ch4_first_general_reg;
  logic [W-1:0] ch5_first_general_reg;

  assign first_pin_action_field = ch3_upper_pin_io_select[3:0];
  assign third_pin_action_field = ch3_lower_pin_io_select[3:0];
  assign buffer_pair_a_enable   = ch3_mode_reg[`MODE_BUF_A_BIT];

  always_comb begin
    u_field[0]   = first_pin_action_field;
    u_field[1]   = third_pin_action_field;
    u_field[2]   = ch4_pin_io_select[3:0];
    u_field[3]   = ch5_pin_io_select[3:0];
    u_inhibit[0] = 1'b0;
    u_inhibit[1] = buffer_pair_a_enable;
    u_inhibit[2] = 1'b0;
    u_inhibit[3] = 1'b0;
    u_count[0]   = ch3_count_i;
    u_count[1]   = ch3_count_i;
    u_count[2]   = ch4_count_i;
    u_count[3]   = ch5_count_i;
    u_tick[0]    = ch3_tick_i;
    u_tick[1]    = ch3_tick_i;
    u_tick[2]    = ch4_tick_i;
    u_tick[3]    = ch5_tick_i;
    u_cascade[0] = ch4_tick_i;
    u_cascade[1] = ch4_tick_i;
    u_cascade[2] = u_event[0];
    u_cascade[3] = 1'b0;
    u_pin_in[0]  = ch3_pin_a_i;
    u_pin_in[1]  = ch3_pin_c_i;
    u_pin_in[2]  = ch4_pin_a_i;
    u_pin_in[3]  = ch5_pin_a_i;
    u_ofs[0]     = `OFS_CH3_FIRST_GR;
    u_ofs[1]     = `OFS_CH3_THIRD_GR;
    u_ofs[2]     = `OFS_CH4_FIRST_GR;
    u_ofs[3]     = `OFS_CH5_FIRST_GR;
  end

  // writes take effect on the edge at which ack rises
  always_comb begin
    wr_go   = cyc_i && stb_i && we_i && !ack_o;
    lanes   = sel_i[1:0];
    wr_word = W'(dat_i);
  end

  genvar g;
  generate
    for (g = 0; g < NU; g++) begin : g_unit
      pin_action_unit #(
        .W           (W),
        .HAS_CASCADE (g != 3),
        .FLAT_CAP    (g == 3)
      ) u_act (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .field_i   (u_field[g]),
        .inhibit_i (u_inhibit[g]),
        .count_i   (u_count[g]),
        .tick_i    (u_tick[g]),
        .cascade_i (u_cascade[g]),
        .pin_i     (u_pin_in[g]),
        .wr_i      (u_wr[g]),
        .wr_data_i (wr_word),
        .gr_o      (u_gr[g]),
        .pin_o     (u_pin[g]),
        .event_o   (u_event[g])
      );
      assign u_wr[g] = wr_go && (adr_i == u_ofs[g]) && (lanes == 2'b11);
    end
  endgenerate

  assign ch3_first_general_reg = u_gr[0];
  assign ch3_third_general_reg = u_gr[1];
  assign ch4_first_general_reg = u_gr[2];
  assign ch5_first_general_reg = u_gr[3];

  // pin drives and event pulses are flops inside the units
  assign ch3_pin_a_o      = u_pin[0].out;
  assign ch3_pin_a_oe_n_o = u_pin[0].oe_n;
  assign ch3_pin_c_o      = u_pin[1].out;
  assign ch3_pin_c_oe_n_o = u_pin[1].oe_n;
  assign ch4_pin_a_o      = u_pin[2].out;
  assign ch4_pin_a_oe_n_o = u_pin[2].oe_n;
  assign ch5_pin_a_o      = u_pin[3].out;
  assign ch5_pin_a_oe_n_o = u_pin[3].oe_n;
  assign event_o          = {u_event[3], u_event[2], u_event[1], u_event[0]};

  // register writes, byte lane 0 carries the 8-bit registers
  always_comb begin
    next_ch3_upper_pin_io_select = ch3_upper_pin_io_select;
    next_ch3_lower_pin_io_select = ch3_lower_pin_io_select;
    next_ch4_pin_io_select       = ch4_pin_io_select;
    next_ch5_pin_io_select       = ch5_pin_io_select;
    next_ch3_mode_reg            = ch3_mode_reg;
    if (wr_go && sel_i[0]) begin
      if (adr_i == `OFS_CH3_UPPER_SEL) begin
        next_ch3_upper_pin_io_select = dat_i[7:0];
      end else if (adr_i == `OFS_CH3_LOWER_SEL) begin
        next_ch3_lower_pin_io_select = dat_i[7:0];
      end else if (adr_i == `OFS_CH4_SEL) begin
        next_ch4_pin_io_select = dat_i[7:0];
      end else if (adr_i == `OFS_CH5_SEL) begin
        next_ch5_pin_io_select = dat_i[7:0];
      end else if (adr_i == `OFS_CH3_MODE) begin
        next_ch3_mode_reg = dat_i[7:0];
      end
    end
  end

  // read mux and single-wait-state ack; unmapped reads return zero
  always_comb begin
    next_ack = cyc_i && stb_i && !ack_o;
    next_dat = 32'h0000_0000;
    if (adr_i == `OFS_CH3_UPPER_SEL) begin
      next_dat[7:0] = ch3_upper_pin_io_select;
    end else if (adr_i == `OFS_CH3_LOWER_SEL) begin
      next_dat[7:0] = ch3_lower_pin_io_select;
    end else if (adr_i == `OFS_CH4_SEL) begin
      next_dat[7:0] = ch4_pin_io_select;
    end else if (adr_i == `OFS_CH5_SEL) begin
      next_dat[7:0] = ch5_pin_io_select;
    end else if (adr_i == `OFS_CH3_MODE) begin
      next_dat[7:0] = ch3_mode_reg;
    end else if (adr_i == `OFS_CH3_FIRST_GR) begin
      next_dat[W-1:0] = ch3_first_general_reg;
    end else if (adr_i == `OFS_CH3_THIRD_GR) begin
      next_dat[W-1:0] = ch3_third_general_reg;
    end else if (adr_i == `OFS_CH4_FIRST_GR) begin
      next_dat[W-1:0] = ch4_first_general_reg;
    end else if (adr_i == `OFS_CH5_FIRST_GR) begin
      next_dat[W-1:0] = ch5_first_general_reg;
    end else if (adr_i == `OFS_PIN_STATUS) begin
      next_dat[7:0] = {u_pin[3].oe_n, u_pin[2].oe_n, u_pin[1].oe_n, u_pin[0].oe_n,
                       u_pin[3].out, u_pin[2].out, u_pin[1].out, u_pin[0].out};
    end
    if (!(cyc_i && stb_i && !we_i && !ack_o)) begin
      next_dat = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ch3_upper_pin_io_select <= `RST_SEL;
      ch3_lower_pin_io_select <= `RST_SEL;
      ch4_pin_io_select       <= `RST_SEL;
      ch5_pin_io_select       <= `RST_SEL;
      ch3_mode_reg            <= `RST_MODE;
      ack_o                   <= 1'b0;
      dat_o                   <= 32'h0000_0000;
    end else begin
      ch3_upper_pin_io_select <= next_ch3_upper_pin_io_select;
      ch3_lower_pin_io_select <= next_ch3_lower_pin_io_select;
      ch4_pin_io_select       <= next_ch4_pin_io_select;
      ch5_pin_io_select       <= next_ch5_pin_io_select;
      ch3_mode_reg            <= next_ch3_mode_reg;
      ack_o                   <= next_ack;
      dat_o                   <= next_dat;
    end
  end
endmodule // timer_pin_io_select_ch3_5

// ### testbench/timer_pin_io_props.sv
// assertions on the ports of the channel 3..5 pin select block
// assumes: bound to the block; one clock with a synchronous reset
`timescale 1ns/100ps
module timer_pin_io_props (
  input wire logic        clk_i,            // clock
  input wire logic        rst_i,            // reset
  input wire logic        cyc_i,            // bus cycle
  input wire logic        stb_i,            // bus strobe
  input wire logic [31:0] dat_o,            // read data
  input wire logic        ack_o,            // acknowledge
  input wire logic        ch3_tick_i,       // ch3 counted
  input wire logic        ch4_tick_i,       // ch4 counted
  input wire logic        ch5_tick_i,       // ch5 counted
  input wire logic        ch3_pin_a_i,      // pin level
  input wire logic        ch3_pin_c_i,      // pin level
  input wire logic        ch4_pin_a_i,      // pin level
  input wire logic        ch5_pin_a_i,      // pin level
  input wire logic        ch3_pin_a_o,      // pin out
  input wire logic        ch3_pin_a_oe_n_o, // pin enable
  input wire logic [3:0]  event_o           // events
);
  logic [3:0] pins, pin_q, pin_qq, moved;
  logic [2:0] ticks, tick_q, tick_r;
  assign pins   = {ch5_pin_a_i, ch4_pin_a_i, ch3_pin_c_i, ch3_pin_a_i};
  assign ticks  = {ch5_tick_i, ch4_tick_i, ch3_tick_i};
  assign moved  = (pins ^ pin_q) | (pin_q ^ pin_qq);
  assign tick_r = ticks | tick_q;
  // history so a cause one or two edges back is accepted
  always_ff @(posedge clk_i) begin
    pin_q  <= pins;
    pin_qq <= pin_q;
    tick_q <= ticks;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_one_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  ack_due_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged");
  rdata_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  pin_cause_a: assert property ($changed(ch3_pin_a_o) |-> event_o[0] || ack_o || $past(ack_o))
    else $error("pin moved without event or write");
  oe_cause_a: assert property ($changed(ch3_pin_a_oe_n_o) |-> ack_o || $past(ack_o))
    else $error("pin enable moved without write");
  first_cause_a: assert property (event_o[0] |-> tick_r[0] || tick_r[1] || moved[0])
    else $error("ch3 first event without cause");
  third_cause_a: assert property (event_o[1] |-> tick_r[0] || tick_r[1] || moved[1])
    else $error("ch3 third event without cause");
  ch4_cause_a: assert property (event_o[2] |-> tick_r[1] || moved[2] || $past(event_o[0]))
    else $error("ch4 event without cause");
  ch5_cause_a: assert property (event_o[3] |-> tick_r[2] || moved[3])
    else $error("ch5 event without cause");
endmodule // timer_pin_io_props

bind timer_pin_io_select_ch3_5 timer_pin_io_props u_props (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
  .ch3_tick_i(ch3_tick_i), .ch4_tick_i(ch4_tick_i), .ch5_tick_i(ch5_tick_i),
  .ch3_pin_a_i(ch3_pin_a_i), .ch3_pin_c_i(ch3_pin_c_i), .ch4_pin_a_i(ch4_pin_a_i),
  .ch5_pin_a_i(ch5_pin_a_i), .ch3_pin_a_o(ch3_pin_a_o), .ch3_pin_a_oe_n_o(ch3_pin_a_oe_n_o),
  .event_o(event_o));

// ### testbench/timer_far_side.sv
// model of the counters and external pin drivers around the block
// assumes: one clock; run bits set by the bench for whole cycles
`timescale 1ns/100ps
module timer_far_side (
  input  wire logic        clk_i,  // clock
  input  wire logic        rst_i,  // reset
  input  wire logic [2:0]  run_i,  // counters 3, 4, 5 advance
  input  wire logic [3:0]  ext_i,  // outside levels on the pins
  input  wire logic [3:0]  out_i,  // block pin levels
  input  wire logic [3:0]  oe_n_i, // block enables, low drives
  output logic      [15:0] cnt_o [3], // counter values
  output logic      [2:0]  tick_o, // counter advanced
  output logic      [3:0]  pin_o   // resolved pin levels
);
  // counter and tick move together on the same edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_o  <= '{16'h0100, 16'h0200, 16'h0300};
      tick_o <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (run_i[i]) cnt_o[i] <= cnt_o[i] + 16'h1;
      end
      tick_o <= run_i;
    end
  end
  // outside driver yields while the block drives
  assign pin_o = (oe_n_i & ext_i) | (~oe_n_i & out_i);
endmodule // timer_far_side

// ### testbench/timer_pin_io_select_ch3_5_tb.sv
// self-checking bench for the channel 3..5 pin select block
// assumes: design files and the far side model compiled before it
`timescale 1ns/100ps
`include "timer_pin_io_params.svh"
module timer_pin_io_select_ch3_5_tb;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack_o;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, dat_o, q;
  logic [3:0]  sel = 4'h0, pout, poe, pin, ev, ext = 4'h0;
  logic [2:0]  run = 3'h0, tick;
  logic [15:0] cnt [3];
  logic [7:0]  so [4] = '{`OFS_CH3_UPPER_SEL, `OFS_CH3_LOWER_SEL, `OFS_CH4_SEL, `OFS_CH5_SEL};
  logic [7:0]  go [4] = '{`OFS_CH3_FIRST_GR, `OFS_CH3_THIRD_GR, `OFS_CH4_FIRST_GR, `OFS_CH5_FIRST_GR};
  int          chn [4] = '{0, 0, 1, 2};
  int          mismatches = 0, tests_run = 0, k, cc, p;
  int          evn [4] = '{0, 0, 0, 0};
  int          e;
  always #5 clk_i = ~clk_i;
  // event pulses seen per unit, each one-cycle pulse sampled once
  always @(posedge clk_i) begin
    if (!rst_i) begin
      for (int i = 0; i < 4; i++) evn[i] += ev[i];
    end
  end
  timer_pin_io_select_ch3_5 dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .ch3_count_i(cnt[0]), .ch3_tick_i(tick[0]), .ch4_count_i(cnt[1]), .ch4_tick_i(tick[1]),
    .ch5_count_i(cnt[2]), .ch5_tick_i(tick[2]),
    .ch3_pin_a_i(pin[0]), .ch3_pin_a_o(pout[0]), .ch3_pin_a_oe_n_o(poe[0]),
    .ch3_pin_c_i(pin[1]), .ch3_pin_c_o(pout[1]), .ch3_pin_c_oe_n_o(poe[1]),
    .ch4_pin_a_i(pin[2]), .ch4_pin_a_o(pout[2]), .ch4_pin_a_oe_n_o(poe[2]),
    .ch5_pin_a_i(pin[3]), .ch5_pin_a_o(pout[3]), .ch5_pin_a_oe_n_o(poe[3]), .event_o(ev));
  timer_far_side far (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .ext_i(ext), .out_i(pout),
    .oe_n_i(poe), .cnt_o(cnt), .tick_o(tick), .pin_o(pin));

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    r = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 20) mismatches++;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(a, 1'b1, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    wb(a, 1'b0, 32'h0, r);
    chk(r, exp);
  endtask
  task automatic count(input logic [2:0] m, input int n);
    @(posedge clk_i);
    run <= m;
    repeat (n) @(posedge clk_i);
    run <= 3'h0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic drive(input int u, input logic v);
    @(posedge clk_i);
    ext[u] <= v;
    repeat (3) @(posedge clk_i);
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, status reads pins low and undriven, unmapped reads zero
    for (int a = 0; a <= 8'h28; a += 4) begin
      rd(8'(a), a == 8'h24 ? 32'hf0 : (a >= 8'h14 && a <= 8'h20) ? 32'hffff : 32'h0);
    end
    wr(8'h28, 32'hff);
    rd(8'h28, 32'h0);
    // every compare code on every unit: initial level, then one match
    for (int u = 0; u < 4; u++) begin
      for (int c = 0; c < 8; c++) begin
        wr(so[u], c);
        rd(so[u], c);
        wb(`OFS_PIN_STATUS, 1'b0, 32'h0, q);
        chk({q[u+4], q[u]}, {c[1:0] == 2'b00, c[2]});
        wr(go[u], cnt[chn[u]] + 16'h2);
        e = evn[u];
        count(3'h1 << chn[u], 4);
        p = c[1:0] == 2'b01 ? 0 : c[1:0] == 2'b10 ? 1 : c[1:0] == 2'b11 ? !c[2] : c[2];
        wb(`OFS_PIN_STATUS, 1'b0, 32'h0, q);
        chk({q[u+4], q[u]}, {c[1:0] == 2'b00, p[0]});
        chk({poe[u], pout[u]}, {c[1:0] == 2'b00, p[0]});
        chk(evn[u] - e, 1);
      end
    end
    // capture codes: rise, fall, both; ch5 ignores the level bit
    for (int u = 0; u < 4; u++) begin
      for (int c = 8; c < 12; c++) begin
        cc = u == 3 ? c + 4 : c;
        k = cnt[chn[u]];
        wr(so[u], cc);
        drive(u, 1'b0);
        wr(go[u], 32'h1234);
        drive(u, 1'b1);
        rd(go[u], c == 9 ? 32'h1234 : k);
        wr(go[u], 32'h1234);
        drive(u, 1'b0);
        rd(go[u], c == 8 ? 32'h1234 : k);
      end
    end
    // ch3 first captures its own counter on a ch4 count
    wr(so[0], 32'hc);
    wr(go[0], 32'h1234);
    count(3'h2, 1);
    rd(go[0], cnt[0]);
    // ch4 captures when ch3 first matches
    wr(so[0], 32'h3);
    wr(go[0], cnt[0] + 16'h2);
    wr(so[2], 32'hc);
    wr(go[2], 32'h1234);
    e = evn[2];
    count(3'h1, 4);
    rd(go[2], cnt[1]);
    chk(evn[2] - e, 1);
    // buffer mode: third field neither drives nor captures
    wr(`OFS_CH3_MODE, 32'h10);
    wr(so[1], 32'h2);
    wr(go[1], cnt[0] + 16'h2);
    e = evn[1];
    count(3'h1, 4);
    wb(`OFS_PIN_STATUS, 1'b0, 32'h0, q);
    chk(q[5], 1'b1);
    wr(so[1], 32'h8);
    wr(go[1], 32'h1234);
    drive(1, 1'b1);
    rd(go[1], 32'h1234);
    chk(evn[1] - e, 0);
    close_out();
  end

  initial begin
    #100000;
    mismatches++;
    close_out();
  end
endmodule // timer_pin_io_select_ch3_5_tb
